// ---- core/pods_map.svh ----
// timing constants of the power-on self-diagnosis sequencer
`ifndef PODS_MAP_SVH
`define PODS_MAP_SVH
`define PODS_CLK_NS 100
`define PODS_REL_MIN_US 20
`define PODS_FALL_TYP_US 10
`define PODS_RISE_TYP_US 10
`define PODS_FIRST_TYP_US 30
`define PODS_EDGE_MIN_US 5
`define PODS_EDGE_MAX_US 15
`define PODS_FIRST_MIN_US 15
`define PODS_FIRST_MAX_US 45
`define PODS_US_CYC(us) ((us) * 1000 / `PODS_CLK_NS)
`define PODS_REL_MIN_CYC `PODS_US_CYC(`PODS_REL_MIN_US)
`define PODS_FALL_CYC `PODS_US_CYC(`PODS_FALL_TYP_US)
`define PODS_RISE_CYC `PODS_US_CYC(`PODS_RISE_TYP_US)
`define PODS_FIRST_CYC `PODS_US_CYC(`PODS_FIRST_TYP_US)
`define PODS_CNT_W 9
`endif

// ---- core/pods_pkg.sv ----
// types of the power-on self-diagnosis sequencer
package pods_pkg;
   typedef enum logic [2:0] {
      PODS_ST_OFF,
      PODS_ST_HELD,
      PODS_ST_WAIT_FALL,
      PODS_ST_DRIVE_LOW,
      PODS_ST_WAIT_FIRST,
      PODS_ST_NORMAL
   } pods_state_t;
endpackage

// ---- core/pods_sequencer.sv ----
// power-on self-diagnosis sequencer of a latching switch sensor
//
// Overview of operation
// - bad request skips diagnosis to normal mode
// - drive line low 5-15 us after release
// - release driver 5-15 us after fall
// - first real output 15-45 us after release
// - normal mode: operate drives low, release frees
`timescale 1ns/1ps
`default_nettype none
`include "pods_map.svh"
module pods_sequencer
   import pods_pkg::*;
(
   input wire logic clock_in, // 10 MHz clock
   input wire logic arst_n_in, // async reset, active low
   input wire logic supply_ok_in, // sensor_supply_level at 90 percent
   input wire logic line_in, // level seen on the shared line
   input wire logic field_operate_in, // field above operate point
   input wire logic field_release_in, // field below release point
   output logic line_out, // value driven on line, always low
   output logic line_oe_out, // high while pulling line low
   output logic diag_active_out, // diagnosis phase running
   output logic normal_mode_out, // normal switching running
   output logic diag_skipped_out // request was invalid, diag skipped
);
   ////////////////////////////////////////////////////////////////
   // state
   pods_state_t state_r; // sequencer state
   pods_state_t state_nxt; // next sequencer state
   logic switch_on_r; // latched switch output in normal mode
   logic switch_on_nxt; // next latched switch output
   logic skipped_r; // diagnosis skipped flag
   logic skipped_nxt; // next skipped flag
   logic oe_r; // driver enable register
   logic oe_nxt; // next driver enable
   pods_timer_if tif (); // timer carrier

   pods_timer u_timer (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////
   // next state and outputs
   always_comb begin
      state_nxt = state_r;
      switch_on_nxt = switch_on_r;
      skipped_nxt = skipped_r;
      oe_nxt = oe_r;
      tif.clear = 1'b0;
      case (state_r)
         PODS_ST_OFF: begin
            // supply up: diagnosis only if host holds line low
            oe_nxt = 1'b0;
            tif.clear = 1'b1;
            if (supply_ok_in) begin
               if (!line_in) begin
                  state_nxt = PODS_ST_HELD;
               end else begin
                  state_nxt = PODS_ST_NORMAL;
                  skipped_nxt = 1'b1;
               end
            end
         end
         PODS_ST_HELD: begin
            // wait for host release, early release skips
            if (line_in) begin
               tif.clear = 1'b1;
               if (tif.count >= 9'(`PODS_REL_MIN_CYC)) begin
                  state_nxt = PODS_ST_WAIT_FALL;
               end else begin
                  state_nxt = PODS_ST_NORMAL;
                  skipped_nxt = 1'b1;
               end
            end
         end
         PODS_ST_WAIT_FALL: begin
            // line pulled high by resistor, then simulated operate
            if (tif.count >= 9'(`PODS_FALL_CYC - 1)) begin
               state_nxt = PODS_ST_DRIVE_LOW;
               oe_nxt = 1'b1;
            end
         end
         PODS_ST_DRIVE_LOW: begin
            // simulated release after typical spacing
            if (tif.count >= 9'(`PODS_FALL_CYC + `PODS_RISE_CYC - 1)) begin
               state_nxt = PODS_ST_WAIT_FIRST;
               oe_nxt = 1'b0;
            end
         end
         PODS_ST_WAIT_FIRST: begin
            // first real data at typical time after release
            if (tif.count >= 9'(`PODS_FIRST_CYC - 1)) begin
               state_nxt = PODS_ST_NORMAL;
               switch_on_nxt = field_operate_in;
               oe_nxt = field_operate_in;
            end
         end
         PODS_ST_NORMAL: begin
            // latching switch with hysteresis_window
            if (field_operate_in) begin
               switch_on_nxt = 1'b1;
            end else if (field_release_in) begin
               switch_on_nxt = 1'b0;
            end
            oe_nxt = switch_on_nxt;
         end
         default: begin
            state_nxt = PODS_ST_OFF;
            oe_nxt = 1'b0;
         end
      endcase
      // supply loss restarts everything
      if (!supply_ok_in) begin
         state_nxt = PODS_ST_OFF;
         oe_nxt = 1'b0;
         skipped_nxt = 1'b0;
         switch_on_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= PODS_ST_OFF;
         switch_on_r <= 1'b0;
         skipped_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         switch_on_r <= switch_on_nxt;
         skipped_r <= skipped_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign line_out = 1'b0; // open drain only ever pulls low
   assign line_oe_out = oe_r;
   assign diag_active_out = (state_r == PODS_ST_WAIT_FALL) || (state_r == PODS_ST_DRIVE_LOW)
      || (state_r == PODS_ST_WAIT_FIRST);
   assign normal_mode_out = (state_r == PODS_ST_NORMAL);
   assign diag_skipped_out = skipped_r;

   ////////////////////////////////////////////////////////////////
   // assertions
   // window bounds in clock cycles, checked against the clock itself
   localparam int CHK_REL_MIN = `PODS_REL_MIN_CYC; // shortest valid hold
   localparam int CHK_EDGE_LO = `PODS_US_CYC(`PODS_EDGE_MIN_US); // earliest diag edge
   localparam int CHK_EDGE_HI = `PODS_US_CYC(`PODS_EDGE_MAX_US); // latest diag edge
   localparam int CHK_FIRST_LO = `PODS_US_CYC(`PODS_FIRST_MIN_US); // earliest real data
   localparam int CHK_FIRST_HI = `PODS_US_CYC(`PODS_FIRST_MAX_US); // latest real data
   logic [`PODS_CNT_W-1:0] held_cyc_r; // own count of held cycles
   logic [`PODS_CNT_W-1:0] held_cyc_nxt; // next held cycle count

   // next held count: step while held, else zero; kept apart from the
   // shared timer so that a broken timer cannot hide an early release
   always_comb begin
      if (state_r != PODS_ST_HELD) begin
         held_cyc_nxt = '0;
      end else if (&held_cyc_r) begin
         held_cyc_nxt = held_cyc_r; // saturate, a long hold stays long
      end else begin
         held_cyc_nxt = held_cyc_r + 9'h001;
      end
   end

   // held count register
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         held_cyc_r <= '0;
      end else begin
         held_cyc_r <= held_cyc_nxt;
      end
   end

   // timing checks give up when supply drops, a diagnosis then restarts
   property p_fall_time;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      $rose(state_r == PODS_ST_WAIT_FALL) |-> ##[CHK_EDGE_LO:CHK_EDGE_HI] line_oe_out;
   endproperty
   a_fall_time: assert property (p_fall_time) else $error("fall edge late");

   // an early pull would still meet the window above, so look back too
   property p_fall_early;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      ($rose(line_oe_out) && state_r == PODS_ST_DRIVE_LOW)
         |-> $past(diag_active_out, CHK_EDGE_LO);
   endproperty
   a_fall_early: assert property (p_fall_early) else $error("fall edge early");

   property p_rise_time;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      ($rose(line_oe_out) && state_r == PODS_ST_DRIVE_LOW) |-> ##[CHK_EDGE_LO:CHK_EDGE_HI]
         !line_oe_out;
   endproperty
   a_rise_time: assert property (p_rise_time) else $error("rise edge late");

   // driver must have been on for the shortest spacing before letting go
   property p_rise_early;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      ($fell(line_oe_out) && state_r == PODS_ST_WAIT_FIRST)
         |-> $past(line_oe_out, CHK_EDGE_LO);
   endproperty
   a_rise_early: assert property (p_rise_early) else $error("rise edge early");

   property p_first_out;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      $rose(state_r == PODS_ST_WAIT_FALL) |-> ##[CHK_FIRST_LO:CHK_FIRST_HI] normal_mode_out;
   endproperty
   a_first_out: assert property (p_first_out) else $error("first output late");

   property p_first_early;
      @(posedge clock_in) disable iff (!arst_n_in || !supply_ok_in)
      ($rose(normal_mode_out) && !diag_skipped_out)
         |-> $past(diag_active_out, CHK_FIRST_LO);
   endproperty
   a_first_early: assert property (p_first_early) else $error("first output early");

   property p_skip;
      @(posedge clock_in) disable iff (!arst_n_in)
      (state_r == PODS_ST_OFF && supply_ok_in && line_in) |=> (normal_mode_out && diag_skipped_out);
   endproperty
   a_skip: assert property (p_skip) else $error("skip not taken");

   property p_operate;
      @(posedge clock_in) disable iff (!arst_n_in)
      (normal_mode_out && field_operate_in && supply_ok_in) |=> line_oe_out;
   endproperty
   a_operate: assert property (p_operate) else $error("operate not driving");

   property p_release;
      @(posedge clock_in) disable iff (!arst_n_in)
      (normal_mode_out && field_release_in && !field_operate_in) |=> !line_oe_out;
   endproperty
   a_release: assert property (p_release) else $error("release still driving");

   property p_early_rel;
      @(posedge clock_in) disable iff (!arst_n_in)
      (state_r == PODS_ST_HELD && line_in && supply_ok_in && held_cyc_r < CHK_REL_MIN)
         |=> diag_skipped_out;
   endproperty
   a_early_rel: assert property (p_early_rel) else $error("early release accepted");

   property p_held_ok;
      @(posedge clock_in) disable iff (!arst_n_in)
      (state_r == PODS_ST_HELD && line_in && supply_ok_in && held_cyc_r >= CHK_REL_MIN)
         |=> diag_active_out && !line_oe_out;
   endproperty
   a_held_ok: assert property (p_held_ok) else $error("valid release not run");
endmodule
`default_nettype wire

// ---- core/pods_timer.sv ----
// saturating cycle timer used by the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pods_map.svh"
module pods_timer (
   input wire logic clock_in, // 10 MHz clock
   input wire logic arst_n_in, // async reset, active low
   pods_timer_if.tmr tif // clear in, count out
);
   logic [`PODS_CNT_W-1:0] count_r; // elapsed cycles
   logic [`PODS_CNT_W-1:0] count_nxt; // next elapsed cycles
   // next count: clear, hold at top, else step
   always_comb begin
      if (tif.clear) begin
         count_nxt = '0;
      end else if (&count_r) begin
         count_nxt = count_r; // saturate so a stale count never wraps
      end else begin
         count_nxt = count_r + 9'h001;
      end
   end
   // count register
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end
   assign tif.count = count_r;
endmodule
`default_nettype wire

// ---- core/pods_timer_if.sv ----
// carrier between sequencer and its cycle timer
`timescale 1ns/1ps
`default_nettype none
interface pods_timer_if;
   logic clear; // restart count at zero
   logic [8:0] count; // cycles since last clear
   modport ctrl (output clear, input count);
   modport tmr (input clear, output count);
endinterface
`default_nettype wire

// ---- test/pods_host_model.sv ----
// host model: powers the sensor, holds the shared line, times the diagnosis edges
`timescale 1ns/1ps
`default_nettype none
module pods_host_model (
   input wire logic clock_in, // bench clock
   input wire logic line_in, // resolved line level
   input wire logic go_in, // start one power cycle
   input wire logic pre_low_in, // pull line low while unpowered
   input wire logic [8:0] hold_in, // cycles from supply to release
   output logic supply_ok_out, // sensor powered
   output logic host_low_out, // host pulls line low
   output int t_out, // cycles since release
   output int fall_out, // diag fall time, -1 if none
   output int rise_out // diag rise time, -1 if none
);
   logic line_q = 1'b1; // line level one cycle ago
   initial begin
      supply_ok_out = 1'b0;
      host_low_out = 1'b0;
      t_out = 0;
      fall_out = -1;
      rise_out = -1;
   end
   // power cycle; a short hold models a careless host
   always @(posedge clock_in) begin
      if (go_in) begin
         supply_ok_out <= 1'b0;
         host_low_out <= pre_low_in;
         repeat (4) @(posedge clock_in);
         supply_ok_out <= 1'b1;
         repeat (hold_in) @(posedge clock_in);
         host_low_out <= 1'b0;
      end
   end
   // edge timer from the release moment, one cycle is 0.1 us
   always @(posedge clock_in) begin
      line_q <= line_in;
      t_out <= host_low_out ? 0 : t_out + 1;
      if (host_low_out || go_in) begin
         fall_out <= -1;
         rise_out <= -1;
      end else if (line_q && !line_in && fall_out < 0) begin
         fall_out <= t_out;
      end else if (!line_q && line_in && fall_out >= 0 && rise_out < 0) begin
         rise_out <= t_out;
      end
   end
endmodule
`default_nettype wire

// ---- test/power_on_self_diagnosis_sequencer_bench.sv ----
// bench of the power-on self-diagnosis sequencer
`timescale 1ns/1ps
`default_nettype none
module power_on_self_diagnosis_sequencer_bench;
   logic clock_in = 1'b0; // 10 MHz
   logic arst_n_in = 1'b0; // async reset
   logic op = 1'b0, rl = 1'b0; // field inputs
   logic go = 1'b0, pre_low = 1'b1; // host commands
   logic [8:0] hold = 9'h0c8; // host hold cycles
   logic supply, host_low, line, oe, dline, diag, norm, skip; // wires
   logic exp_oe = 1'b0; // expected driver state
   int t, fall, rise, miscompares = 0, checks_done = 0;
   // open-drain line with pull-up
   assign line = !(host_low || (oe && !dline));
   initial forever #50 clock_in = ~clock_in;
   pods_sequencer dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .supply_ok_in(supply),
      .line_in(line), .field_operate_in(op), .field_release_in(rl), .line_out(dline),
      .line_oe_out(oe), .diag_active_out(diag), .normal_mode_out(norm),
      .diag_skipped_out(skip));
   pods_host_model host (.clock_in(clock_in), .line_in(line), .go_in(go),
      .pre_low_in(pre_low), .hold_in(hold), .supply_ok_out(supply),
      .host_low_out(host_low), .t_out(t), .fall_out(fall), .rise_out(rise));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // window test in cycles of 0.1 us
   function automatic logic in_win(input int v, input int lo_b, input int hi_b);
      return v >= lo_b && v <= hi_b;
   endfunction
   // one power cycle; stop > 0 leaves it at that many cycles after release
   task automatic power_up(input logic low, input logic [8:0] h, input int stop, output int tn);
      pre_low <= low;
      hold <= h;
      go <= 1'b1;
      @(posedge clock_in);
      go <= 1'b0;
      tn = -1;
      for (int i = 0; i < 1200 && tn < 0; i++) begin
         @(posedge clock_in);
         #1;
         if (i == 0) check("supply_loss", {diag, oe, norm, skip}, 4'h0);
         if (stop > 0 && supply === 1'b1 && host_low === 1'b0 && t == stop) return;
         if (supply === 1'b1 && norm === 1'b1) tn = t;
      end
      if (tn < 0) begin
         check("normal_timeout", 1'b0, 1'b1);
         final_report();
      end
   endtask
   initial begin
      int tn;
      void'($urandom(32'h2958a110));
      repeat (6) @(posedge clock_in);
      arst_n_in <= 1'b1;
      check("reset_state", {oe, diag, norm, skip}, 4'h0);
      // supply lost in mid-diagnosis, retried below
      power_up(1'b1, 9'h0d0, 40, tn);
      check("mid_diag", {diag, norm}, 2'b10);
      // proper requests, hold just above and well above the minimum
      for (int k = 0; k < 3; k++) begin
         power_up(1'b1, 9'(205 + k * 100 + $urandom % 40), 0, tn);
         check("skip_proper", skip, 1'b0);
         check("fall_win", in_win(fall, 50, 150), 1'b1);
         check("rise_win", in_win(rise - fall, 50, 150), 1'b1);
         check("first_win", in_win(tn, 150, 450), 1'b1);
      end
      // normal switching with random field, operate wins
      for (int k = 0; k < 40; k++) begin
         @(posedge clock_in);
         op <= 1'($urandom % 2);
         rl <= 1'($urandom % 2);
         @(posedge clock_in);
         #1;
         exp_oe = op ? 1'b1 : (rl ? 1'b0 : exp_oe);
         check("normal_oe", oe, exp_oe);
      end
      @(posedge clock_in);
      op <= 1'b0;
      rl <= 1'b0;
      // early release, then line left high at power-up
      power_up(1'b1, 9'(20 + $urandom % 150), 0, tn);
      check("skip_early", {skip, norm, fall < 0}, 3'b111);
      power_up(1'b0, 9'h0c8, 0, tn);
      check("skip_high", {skip, norm, fall < 0}, 3'b111);
      final_report();
   end
endmodule
`default_nettype wire
